/* pit_pkg.sv */
package pit_pkg;

  // ==========================================================================
  // Register port map (byte addresses).
  localparam logic [3:0] OFS_CNT0 = 4'h0;
  localparam logic [3:0] OFS_CNT1 = 4'h4;
  localparam logic [3:0] OFS_CNT2 = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hc;

  // ==========================================================================
  // Control byte fields.
  localparam int SEL_LSB  = 6;
  localparam int ACC_LSB  = 4;
  localparam int MODE_LSB = 1;
  localparam int BCD_BIT  = 0;

  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  localparam logic [1:0] ACC_LATCH   = 2'h0;
  localparam logic [1:0] ACC_LOW     = 2'h1;
  localparam logic [1:0] ACC_HIGH    = 2'h2;
  localparam logic [1:0] ACC_BOTH    = 2'h3;

  localparam int          NUM_CNT    = 3;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_TWO    = 16'h0002;
  localparam logic [15:0] CNT_THREE  = 16'h0003;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [3:0]  BCD_NINE   = 4'h9;
  localparam logic [3:0]  BCD_ZERO   = 4'h0;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    MODE_INT_TC,
    MODE_ONE_SHOT,
    MODE_RATE,
    MODE_SQUARE,
    MODE_SW_STROBE,
    MODE_HW_STROBE
  } pit_mode_t;

  typedef struct packed {
    pit_mode_t  mode;
    logic [1:0] access;
    logic       bcd;
  } pit_cfg_t;

  localparam pit_cfg_t CFG_RESET = '{mode: MODE_INT_TC, access: ACC_LATCH, bcd: 1'b0};

endpackage

/* pit_properties.sv */
`timescale 1ns/1ps
module pit_properties
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Counter pins
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  input wire logic [2:0] cnt_out
);
  // ==========================================================================
  // Event history
  // An output may only move a few cycles after its clock falls, its gate
  // changes or the host writes; anything else means crosstalk between counters.
  logic [2:0]      clk_q;
  logic [2:0]      gate_q;
  logic [7:0][2:0] hist_q;
  wire  [2:0]      ev  = (clk_q & ~cnt_clk) | (gate_q ^ cnt_gate) | {3{reg_wr}};
  wire  [2:0]      act = hist_q[0] | hist_q[1] | hist_q[2] | hist_q[3] | hist_q[4] | hist_q[5] | hist_q[6] | hist_q[7];
  wire             cwr = reg_wr && reg_addr == pit_pkg::OFS_CTRL;

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      clk_q  <= 3'h0;
      gate_q <= 3'h0;
      hist_q <= '0;
    end
    else
    begin
      clk_q  <= cnt_clk;
      gate_q <= cnt_gate;
      hist_q <= {hist_q[6:0], ev};
    end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  reset_vals_a: assert property ($rose(reset_n) |-> cnt_out == 3'h7 && reg_rdata == 8'h00)
    else $error("outputs wrong after reset");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  ctrl_read_a: assert property (reg_rd && reg_addr == pit_pkg::OFS_CTRL |=> reg_rdata == 8'h00)
    else $error("control port read not zero");
  unmapped_read_a: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  out_cause_a: assert property (((cnt_out ^ $past(cnt_out)) & ~act) == 3'h0)
    else $error("output moved without a cause");
  zero_set_a: assert property (cwr && reg_wdata[7:6] == 2'h1 && reg_wdata[5:4] != 2'h0 && reg_wdata[3:1] == 3'h0
    |-> ##[1:4] !cnt_out[1])
    else $error("mode zero set left output high");
  swstrobe_set_a: assert property (cwr && reg_wdata[7:6] == 2'h1 && reg_wdata[5:4] != 2'h0 && reg_wdata[3:1] == 3'h4
    |-> ##[1:4] cnt_out[1])
    else $error("mode four set left output low");
  rate_idle_a: assert property (cwr && reg_wdata[7:4] == 4'h3 && reg_wdata[2:1] == 2'h2 |-> ##4 cnt_out[0] [*4])
    else $error("mode two output not high before load");

  cover property (cwr && reg_wdata[5:4] == 2'h0);
  cover property ($fell(cnt_out[0]));
  cover property (reg_rd && reg_addr[1:0] != 2'h0);
endmodule

bind pit_timer pit_properties u_props (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate),
  .cnt_out(cnt_out));

/* pit_timer.sv */
`timescale 1ns/1ps

// Operation
// RL1: Three independent 16-bit counters, each with its own mode from its control word.
// RL2: Each count access follows the last control byte written to that counter.
// RL3: Counter data ports at the first three locations, control at the fourth.
// RL4: Control bits 7:6 pick the counter; code 11 selects nothing.
// RL5: Control bits 5:4 pick latch, low byte, high byte, or low then high.
// RL6: Control bits 3:1 pick mode; bit 3 ignored for modes two and three.
// RL7: Control bit 0 picks 16-bit binary or four-decade BCD counting.
// RL8: Mode zero output low while counting, high at terminal count until reload.
// RL9: Mode zero first byte of a new count halts; second byte restarts.
// RL10: Mode one output low after gate rise, high at terminal count.
// RL11: Mode one retriggers a full low count on every gate rise.
// RL12: Mode one count reads never disturb the pulse in progress.
// RL13: Mode two divides by N, one clock low; reload affects next period.
// RL14: Mode two low gate forces output high; gate rise restarts count.
// RL15: Mode two output stays high until a count is loaded.
// RL16: Mode three square wave, decrement by two, toggle and reload at end.
// RL17: Mode three odd count: high (N+1)/2, low (N-1)/2 clocks.
// RL18: In modes two and three the host pulses gate after a new count.
// RL19: Mode four high after set, counts after load, one clock low strobe.
// RL20: Mode four reload taken next clock; gate low suspends counting.
// RL21: Mode five counts after gate rise, strobes low once, retriggerable.
// RL22: Latch command freezes the count into a holding register for reads.
module pit_timer
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Counter pins
  input  wire logic [2:0] cnt_clk,
  input  wire logic [2:0] cnt_gate,
  output logic      [2:0] cnt_out
);

  // ==========================================================================
  // Helpers.
  function automatic pit_pkg::pit_mode_t decode_mode(input logic [2:0] m);
    pit_pkg::pit_mode_t r;
    r = pit_pkg::MODE_INT_TC;
    if (m[1:0] == 2'h2)
    begin
      r = pit_pkg::MODE_RATE;
    end
    else if (m[1:0] == 2'h3)
    begin
      r = pit_pkg::MODE_SQUARE;
    end
    else if (m == 3'h1)
    begin
      r = pit_pkg::MODE_ONE_SHOT;
    end
    else if (m == 3'h4)
    begin
      r = pit_pkg::MODE_SW_STROBE;
    end
    else if (m == 3'h5)
    begin
      r = pit_pkg::MODE_HW_STROBE;
    end
    return r;
  endfunction

  // Decrement by one in binary or in four BCD decades.
  function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v - pit_pkg::CNT_ONE;
    borrow = 1'b1;
    if (bcd)
    begin
      r = v;
      for (int k = 0; k < 4; k++)
      begin
        if (borrow)
        begin
          if (r[4*k +: 4] == pit_pkg::BCD_ZERO)
          begin
            r[4*k +: 4] = pit_pkg::BCD_NINE;
          end
          else
          begin
            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Address decode.
  wire logic [1:0] ctl_sel  = reg_wdata[pit_pkg::SEL_LSB +: 2];
  wire logic       ctl_wr   = reg_wr && (reg_addr == pit_pkg::OFS_CTRL);
  wire logic [2:0] data_hit;
  assign data_hit[0] = (reg_addr == pit_pkg::OFS_CNT0); // RL3
  assign data_hit[1] = (reg_addr == pit_pkg::OFS_CNT1); // RL3
  assign data_hit[2] = (reg_addr == pit_pkg::OFS_CNT2); // RL3

  logic [7:0] rd_byte [pit_pkg::NUM_CNT];
  wire  logic [7:0] rd_sel = data_hit[0] ? rd_byte[0] :
                             data_hit[1] ? rd_byte[1] :
                             data_hit[2] ? rd_byte[2] : pit_pkg::BYTE_ZERO;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= pit_pkg::BYTE_ZERO;
    else if (reg_rd)
      reg_rdata <= rd_sel;
  end

  // ==========================================================================
  // Counters.
  genvar gi;
  generate
    for (gi = 0; gi < pit_pkg::NUM_CNT; gi++)
    begin : g_cnt
      logic [2:0]        csync_q;
      logic [2:0]        gsync_q;
      logic              clk_lvl_q;
      logic              gate_lvl_q;
      logic              gtrig_q;
      pit_pkg::pit_cfg_t cfg_q;
      logic [15:0]       count_q;
      logic [15:0]       reload_q;
      logic [15:0]       latch_q;
      logic              latched_q;
      logic              wptr_q;
      logic              rptr_q;
      logic              armed_q;
      logic              new_q;
      logic              run_q;
      logic              out_q;
      logic              odd_q;

      // Pins are filtered: a level counts once the second and third stages agree.
      wire logic stable_c  = (csync_q[1] == csync_q[2]);
      wire logic stable_g  = (gsync_q[1] == gsync_q[2]);
      wire logic clk_fall  = clk_lvl_q && stable_c && !csync_q[2];
      wire logic gate_rise = !gate_lvl_q && stable_g && gsync_q[2];
      wire logic trig      = gtrig_q || gate_rise;
      wire logic gate_now  = stable_g ? gsync_q[2] : gate_lvl_q;

      wire logic ctl_hit   = ctl_wr && (ctl_sel == 2'(gi)) && (ctl_sel != pit_pkg::SEL_ILLEGAL); // RL4
      wire logic ctl_latch = ctl_hit && (reg_wdata[pit_pkg::ACC_LSB +: 2] == pit_pkg::ACC_LATCH);
      wire logic dat_wr    = reg_wr && data_hit[gi];
      wire logic dat_rd    = reg_rd && data_hit[gi];
      wire logic both      = (cfg_q.access == pit_pkg::ACC_BOTH);
      wire logic load_done = dat_wr && (!both || wptr_q);
      wire logic [15:0] src   = latched_q ? latch_q : count_q;
      wire logic        hi_rd = (cfg_q.access == pit_pkg::ACC_HIGH) || (both && rptr_q);

      // Steps of one, two and three for the square wave.
      wire logic [15:0] d1 = dec1(count_q, cfg_q.bcd); // RL7
      wire logic [15:0] d2 = dec1(d1, cfg_q.bcd);
      wire logic [15:0] d3 = dec1(d2, cfg_q.bcd);
      wire logic [15:0] sq_step = !odd_q ? pit_pkg::CNT_TWO : (out_q ? pit_pkg::CNT_ONE : pit_pkg::CNT_THREE); // RL17
      wire logic [15:0] sq_next = !odd_q ? d2 : (out_q ? d1 : d3);
      wire logic        sq_end  = (count_q != pit_pkg::CNT_RESET) && (count_q <= sq_step);

      assign rd_byte[gi] = hi_rd ? src[15:8] : src[7:0]; // RL2
      assign cnt_out[gi] = out_q;

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          csync_q    <= 3'h0;
          gsync_q    <= 3'h0;
          clk_lvl_q  <= 1'b0;
          gate_lvl_q <= 1'b0;
          gtrig_q    <= 1'b0;
        end
        else
        begin
          csync_q <= {csync_q[1:0], cnt_clk[gi]};
          gsync_q <= {gsync_q[1:0], cnt_gate[gi]};
          if (stable_c)
            clk_lvl_q <= csync_q[2];
          if (stable_g)
            gate_lvl_q <= gsync_q[2];
          // A rise is held until a counter clock edge consumes it; a control write drops a stale one.
          if (clk_fall || ctl_hit)
            gtrig_q <= 1'b0;
          else if (gate_rise)
            gtrig_q <= 1'b1;
        end
      end

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          cfg_q     <= pit_pkg::CFG_RESET;
          count_q   <= pit_pkg::CNT_RESET;
          reload_q  <= pit_pkg::CNT_RESET;
          latch_q   <= pit_pkg::CNT_RESET;
          latched_q <= 1'b0;
          wptr_q    <= 1'b0;
          rptr_q    <= 1'b0;
          armed_q   <= 1'b0;
          new_q     <= 1'b0;
          run_q     <= 1'b0;
          out_q     <= 1'b1;
          odd_q     <= 1'b0;
        end
        else if (ctl_latch)
        begin
          latch_q   <= count_q; // RL22
          latched_q <= 1'b1;
        end
        else if (ctl_hit)
        begin
          cfg_q.mode   <= decode_mode(reg_wdata[pit_pkg::MODE_LSB +: 3]); // RL1 RL6
          cfg_q.access <= reg_wdata[pit_pkg::ACC_LSB +: 2]; // RL5
          cfg_q.bcd    <= reg_wdata[pit_pkg::BCD_BIT]; // RL7
          out_q        <= (decode_mode(reg_wdata[pit_pkg::MODE_LSB +: 3]) != pit_pkg::MODE_INT_TC); // RL8 RL15 RL19
          wptr_q       <= 1'b0;
          rptr_q       <= 1'b0;
          latched_q    <= 1'b0;
          armed_q      <= 1'b0;
          new_q        <= 1'b0;
          run_q        <= 1'b0;
        end
        else
        begin
          if (dat_rd)
          begin
            // Reads only move the byte pointer and release the latch after the last byte; counting is untouched.
            rptr_q <= both && !rptr_q; // RL12
            if (!both || rptr_q)
              latched_q <= 1'b0; // RL22
          end
          if (dat_wr)
          begin
            wptr_q <= both && !wptr_q; // RL5
            if (cfg_q.access == pit_pkg::ACC_HIGH)
              reload_q <= {reg_wdata, pit_pkg::BYTE_ZERO};
            else if (both && wptr_q)
              reload_q[15:8] <= reg_wdata;
            else
              reload_q <= {pit_pkg::BYTE_ZERO, reg_wdata};
            if (cfg_q.mode == pit_pkg::MODE_INT_TC)
            begin
              if (!load_done)
                run_q <= 1'b0; // RL9
              out_q <= 1'b0; // RL8
            end
          end
          if (load_done)
          begin
            armed_q <= 1'b1;
            // Rate and square modes keep the period in flight once running.
            if (!(run_q && (cfg_q.mode == pit_pkg::MODE_RATE || cfg_q.mode == pit_pkg::MODE_SQUARE))) // RL13
              new_q <= 1'b1;
          end
          else if (clk_fall)
          begin
            case (cfg_q.mode)
              pit_pkg::MODE_INT_TC:
              begin
                if (new_q)
                begin
                  count_q <= reload_q; // RL9
                  new_q   <= 1'b0;
                  run_q   <= 1'b1;
                end
                else if (run_q && gate_now)
                begin
                  count_q <= d1; // RL8
                  if (count_q == pit_pkg::CNT_ONE)
                    out_q <= 1'b1; // RL8
                end
              end
              pit_pkg::MODE_ONE_SHOT:
              begin
                if (trig && armed_q)
                begin
                  count_q <= reload_q; // RL10 RL11
                  out_q   <= 1'b0; // RL10
                  new_q   <= 1'b0;
                end
                else
                begin
                  count_q <= d1;
                  if (count_q == pit_pkg::CNT_ONE)
                    out_q <= 1'b1; // RL10
                end
              end
              pit_pkg::MODE_RATE:
              begin
                if (!gate_now)
                  out_q <= 1'b1; // RL14
                else if (armed_q && (new_q || trig))
                begin
                  count_q <= reload_q; // RL14 RL15
                  new_q   <= 1'b0;
                  run_q   <= 1'b1;
                  out_q   <= 1'b1;
                end
                else if (run_q)
                begin
                  out_q <= (count_q != pit_pkg::CNT_TWO); // RL13
                  count_q <= (count_q == pit_pkg::CNT_ONE) ? reload_q : d1; // RL13
                end
              end
              pit_pkg::MODE_SQUARE:
              begin
                if (!gate_now)
                  out_q <= 1'b1;
                else if (armed_q && (new_q || trig))
                begin
                  count_q <= reload_q;
                  odd_q   <= reload_q[0];
                  new_q   <= 1'b0;
                  run_q   <= 1'b1;
                  out_q   <= 1'b1;
                end
                else if (run_q)
                begin
                  if (sq_end)
                  begin
                    out_q   <= !out_q; // RL16
                    count_q <= reload_q; // RL16
                    odd_q   <= reload_q[0]; // RL17
                  end
                  else
                  begin
                    count_q <= sq_next; // RL16 RL17
                    odd_q   <= 1'b0;
                  end
                end
              end
              default:
              begin
                // Both strobe modes: mode four starts on load, mode five on a gate rise.
                out_q <= 1'b1;
                if (cfg_q.mode == pit_pkg::MODE_HW_STROBE ? (trig && armed_q) : new_q)
                begin
                  count_q <= reload_q; // RL20 RL21
                  new_q   <= 1'b0;
                  run_q   <= 1'b1;
                end
                else if (run_q && (gate_now || cfg_q.mode == pit_pkg::MODE_HW_STROBE)) // RL20
                begin
                  count_q <= d1;
                  if (count_q == pit_pkg::CNT_ONE)
                  begin
                    out_q <= 1'b0; // RL19 RL21
                    run_q <= 1'b0;
                  end
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate

endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  logic       mclk;
  logic       reset_n;
  logic [3:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [2:0] cnt_clk;
  logic [2:0] cnt_gate;
  logic [2:0] cnt_out;
  int         num_errors;
  int         checks_done;

  pit_timer uut
  (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .cnt_clk   (cnt_clk),
    .cnt_gate  (cnt_gate),
    .cnt_out   (cnt_out)
  );

  always #2.5 mclk = ~mclk;

  // ==========================================================================
  // Helpers
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask

  task automatic ld(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask

  task automatic lat(input logic [7:0] c, input logic [3:0] a, input logic [15:0] e, input string n);
    logic [7:0] lo;
    logic [7:0] hi;
    wr(pit_pkg::OFS_CTRL, c);
    rd(a, lo);
    rd(a, hi);
    chk(n, e, {hi, lo});
  endtask

  // Output is read 10 mclk after each fall, well past the input filter.
  task automatic ed(input int i, input int n, output logic [15:0] lows);
    lows = 16'h0000;
    repeat (n)
    begin
      cnt_clk[i] = 1'b1;
      repeat (10) @(negedge mclk);
      cnt_clk[i] = 1'b0;
      repeat (10) @(negedge mclk);
      lows = lows + {15'h0000, cnt_out[i] === 1'b0};
    end
  endtask

  task automatic gp(input int i);
    cnt_gate[i] = 1'b0;
    repeat (4) @(negedge mclk);
    cnt_gate[i] = 1'b1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_rate;
    logic [15:0] l;
    wr(pit_pkg::OFS_CTRL, 8'h34);
    ed(0, 2, l);
    chk("rate_idle", 16'h0000, l);
    ld(pit_pkg::OFS_CNT0, 16'h0003);
    gp(0);
    for (int k = 1; k <= 6; k++)
    begin
      ed(0, 1, l);
      chk("rate_out", (k % 3 == 0) ? 16'h0000 : 16'h0001, {15'h0000, cnt_out[0]});
    end
    cnt_gate[0] = 1'b0;
    ed(0, 3, l);
    chk("rate_gate_low", 16'h0000, l);
    cnt_gate[0] = 1'b1;
    ed(0, 2, l);
    chk("rate_restart", 16'h0000, l);
    ed(0, 1, l);
    chk("rate_restart_pulse", 16'h0001, l);
  endtask

  task automatic t_zero;
    logic [15:0] l;
    logic [7:0]  b;
    wr(pit_pkg::OFS_CTRL, 8'h70);
    ld(pit_pkg::OFS_CNT1, 16'h0005);
    chk("zero_set_out", 16'h0000, {15'h0000, cnt_out[1]});
    ed(1, 3, l);
    lat(8'h40, pit_pkg::OFS_CNT1, 16'h0003, "latch_value");
    ed(1, 2, l);
    chk("zero_before_tc", 16'h0000, {15'h0000, cnt_out[1]});
    ed(1, 1, l);
    chk("zero_tc", 16'h0001, {15'h0000, cnt_out[1]});
    ed(1, 1, l);
    lat(8'h40, pit_pkg::OFS_CNT1, 16'hffff, "zero_wrap");
    wr(pit_pkg::OFS_CTRL, 8'h50);
    wr(pit_pkg::OFS_CNT1, 8'h09);
    ed(1, 2, l);
    rd(pit_pkg::OFS_CNT1, b);
    chk("low_only", 16'h0008, {8'h00, b});
    wr(pit_pkg::OFS_CTRL, 8'h60);
    wr(pit_pkg::OFS_CNT1, 8'h02);
    ed(1, 2, l);
    rd(pit_pkg::OFS_CNT1, b);
    chk("high_only", 16'h0001, {8'h00, b});
  endtask

  task automatic t_bcd;
    logic [15:0] l;
    logic [7:0]  b;
    wr(pit_pkg::OFS_CTRL, 8'hb1);
    ld(pit_pkg::OFS_CNT2, 16'h0010);
    ed(2, 2, l);
    lat(8'h80, pit_pkg::OFS_CNT2, 16'h0009, "bcd_value");
    wr(pit_pkg::OFS_CNT2, 8'h05);
    ed(2, 20, l);
    chk("halt_first_byte", 16'h0000, {15'h0000, cnt_out[2]});
    wr(pit_pkg::OFS_CNT2, 8'h00);
    ed(2, 5, l);
    chk("restart_low", 16'h0000, {15'h0000, cnt_out[2]});
    ed(2, 1, l);
    chk("restart_tc", 16'h0001, {15'h0000, cnt_out[2]});
    wr(pit_pkg::OFS_CTRL, 8'hf0);
    rd(4'h2, b);
    chk("unmapped_read", 16'h0000, {8'h00, b});
    rd(pit_pkg::OFS_CTRL, b);
    chk("ctrl_read", 16'h0000, {8'h00, b});
    chk("illegal_select", 16'h0001, {15'h0000, cnt_out[2]});
  endtask

  task automatic t_square;
    logic [15:0] l;
    wr(pit_pkg::OFS_CTRL, 8'h3e);
    ld(pit_pkg::OFS_CNT0, 16'h0005);
    gp(0);
    ed(0, 7, l);
    ed(0, 10, l);
    chk("square_low_time", 16'h0004, l);
  endtask

  task automatic t_strobe;
    logic [15:0] l;
    logic [15:0] l2;
    logic [7:0]  b;
    cnt_gate[1] = 1'b0;
    wr(pit_pkg::OFS_CTRL, 8'h78);
    ld(pit_pkg::OFS_CNT1, 16'h0003);
    ed(1, 8, l);
    chk("sw_gate_low", 16'h0000, l);
    cnt_gate[1] = 1'b1;
    ed(1, 8, l);
    chk("sw_strobe", 16'h0001, l);
    wr(pit_pkg::OFS_CTRL, 8'hba);
    ld(pit_pkg::OFS_CNT2, 16'h0003);
    ed(2, 8, l);
    chk("hw_no_trigger", 16'h0000, l);
    gp(2);
    ed(2, 8, l);
    chk("hw_strobe", 16'h0001, l);
    wr(pit_pkg::OFS_CTRL, 8'hb2);
    ld(pit_pkg::OFS_CNT2, 16'h0003);
    gp(2);
    ed(2, 8, l);
    chk("shot_pulse", 16'h0003, l);
    gp(2);
    ed(2, 2, l);
    rd(pit_pkg::OFS_CNT2, b);
    chk("shot_read", 16'h0002, {8'h00, b});
    gp(2);
    ed(2, 8, l2);
    chk("shot_retrigger", 16'h0005, l + l2);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    mclk        = 1'b0;
    reset_n     = 1'b0;
    reg_addr    = 4'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_wdata   = 8'h00;
    cnt_clk     = 3'h0;
    cnt_gate    = 3'h7;
    num_errors  = 0;
    checks_done = 0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    chk("reset_out", 16'h0007, {13'h0000, cnt_out});
    t_rate();
    t_zero();
    t_bcd();
    t_square();
    t_strobe();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end
endmodule
